/* File: hw/srp_defines.svh */
// constants of the serial register port: map layout, defaults, sizes
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// ----------------------------------------------------------------
// map layout
// ----------------------------------------------------------------
`define SRP_ADDR_W 7
`define SRP_MAP_SIZE 57
`define SRP_ADDR_STATUS 7'h00
`define SRP_ADDR_ID 7'h38
`define SRP_ADDR_LAST 7'h38
`define SRP_ADDR_FIRST 7'h00

// ----------------------------------------------------------------
// command byte and framing
// ----------------------------------------------------------------
`define SRP_CMD_READ 1'b1
`define SRP_BIT_LAST 3'h7

// ----------------------------------------------------------------
// reset values of the read/write registers
// ----------------------------------------------------------------
`define SRP_DFLT_ZERO 8'h00
`define SRP_DFLT_01 8'haa
`define SRP_DFLT_02 8'h08
`define SRP_DFLT_06 8'h0c
`define SRP_DFLT_07 8'h01
`define SRP_DFLT_09 8'h2d
`define SRP_DFLT_0A 8'h93
`define SRP_DFLT_0B 8'h86

// ----------------------------------------------------------------
// sizes and identity
// ----------------------------------------------------------------
`define SRP_FIFO_DEPTH 16
`define SRP_ID_CODE 8'h5a

`endif

/* File: hw/srp_pkg.sv */
// types and shared functions of the serial register port
`include "srp_defines.svh"

package srp_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [7:0] srp_byte_t;
  typedef logic [`SRP_ADDR_W-1:0] srp_addr_t;

  typedef struct packed {
    srp_addr_t addr;
    srp_byte_t data;
  } srp_wr_s;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_WR,
    PH_RD
  } srp_phase_e;

  // ----------------------------------------------------------------
  // reset value of each map entry
  // ----------------------------------------------------------------
  function automatic srp_byte_t srp_default(input srp_addr_t a);
    case (a)
      7'h01: srp_default = `SRP_DFLT_01;
      7'h02: srp_default = `SRP_DFLT_02;
      7'h06: srp_default = `SRP_DFLT_06;
      7'h07: srp_default = `SRP_DFLT_07;
      7'h09: srp_default = `SRP_DFLT_09;
      7'h0a: srp_default = `SRP_DFLT_0A;
      7'h0b: srp_default = `SRP_DFLT_0B;
      default: srp_default = `SRP_DFLT_ZERO;
    endcase
  endfunction

  // status and identity entries are read-only
  function automatic logic srp_writable(input srp_addr_t a);
    srp_writable = (a != `SRP_ADDR_STATUS) && (a < `SRP_ADDR_ID);
  endfunction

endpackage

/* File: hw/srp_fifo.sv */
// dual-clock fifo with gray-coded pointers, valid/ready on both sides
`timescale 1ns/1ps

module srp_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // write side
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = AW + 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("srp_fifo: depth must be a power of two of at least 2");
  end

  // ----------------------------------------------------------------
  // pointer arithmetic
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // write domain
  // ----------------------------------------------------------------
  logic [PW-1:0] wbin_q, wbin_d, wgray_q, wgray_d;
  logic [PW-1:0] rg_meta_q, rg_sync_q;
  logic [PW-1:0] rbin_q, rbin_d, rgray_q, rgray_d;
  logic push;

  always_comb begin
    wr_ready = (wbin_q - gray2bin(rg_sync_q)) != PW'(DEPTH);
    push = wr_valid & wr_ready;
    wbin_d = push ? wbin_q + PW'(1) : wbin_q;
    wgray_d = bin2gray(wbin_d);
  end

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg_meta_q <= '0;
      rg_sync_q <= '0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rg_meta_q <= rgray_q;
      rg_sync_q <= rg_meta_q;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // read domain
  // ----------------------------------------------------------------
  logic [PW-1:0] wg_meta_q, wg_sync_q;

  always_comb begin
    rd_valid = gray2bin(wg_sync_q) != rbin_q;
    rd_data = mem[rbin_q[AW-1:0]];
    rbin_d = (rd_valid & rd_ready) ? rbin_q + PW'(1) : rbin_q;
    rgray_d = bin2gray(rbin_d);
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg_meta_q <= '0;
      wg_sync_q <= '0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wg_meta_q <= wgray_q;
      wg_sync_q <= wg_meta_q;
    end
  end

endmodule

/* File: hw/srp_port.sv */
// serial register port: link shifter, register map and core image
`timescale 1ns/1ps
`include "srp_defines.svh"

// ----------------------------------------------------------------
// Summary of operation
// - cs_n low opens a burst; cs_n rising ends it.
// - sdi sampled on sclk rising edges, each byte msb first.
// - sdo stays high impedance unless cs_n low and read data returns.
// - map of 57 byte-wide registers reached through the serial port.
// - first byte: upper 7 bits address, lsb 1 read, 0 write.
// - write data goes to address, then next addresses until cs_n rises.
// - address pointer past its top value wraps to zero.
// - read command turns on sdo and streams bytes from rising addresses.
// - during a read burst further sdi bits are ignored.
// - top address holds a read-only identification byte.
// ----------------------------------------------------------------

module srp_port
  import srp_pkg::*;
#(
  parameter srp_byte_t ID_CODE = `SRP_ID_CODE, // arbitrary value
  parameter int FIFO_DEPTH = `SRP_FIFO_DEPTH
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // core status in
  input wire logic [7:0] core_status,
  input wire logic core_busy,
  // core register image out
  output logic [`SRP_MAP_SIZE*8-1:0] reg_image,
  output logic wr_evt,
  output srp_wr_s wr_evt_data,
  output logic fifo_ready
);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("srp_port: fifo depth too small");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic srp_addr_t ptr_next(input srp_addr_t p);
    if (p >= `SRP_ADDR_LAST) begin
      ptr_next = `SRP_ADDR_FIRST;
    end else begin
      ptr_next = p + 7'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // link reset held from the system clock
  // ----------------------------------------------------------------
  logic link_rst_q;
  logic frame_rst;

  always_ff @(posedge mclk) begin
    link_rst_q <= sys_rst;
  end

  // cs_n high clears the frame at once, with no sclk edge needed
  assign frame_rst = cs_n | link_rst_q;

  // ----------------------------------------------------------------
  // status bits carried onto the link clock
  // ----------------------------------------------------------------
  srp_byte_t stat_meta_q, stat_sync_q;

  always_ff @(posedge sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      stat_meta_q <= 8'h00;
      stat_sync_q <= 8'h00;
    end else begin
      stat_meta_q <= core_status;
      stat_sync_q <= stat_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // link-side register mirror
  // ----------------------------------------------------------------
  srp_byte_t mirror_q [`SRP_MAP_SIZE];
  srp_byte_t mirror_d [`SRP_MAP_SIZE];
  srp_addr_t rd_addr;
  srp_byte_t rd_byte;

  // ----------------------------------------------------------------
  // link shifter state
  // ----------------------------------------------------------------
  srp_phase_e phase_q, phase_d;
  logic [2:0] bit_q, bit_d;
  srp_addr_t ptr_q, ptr_d;
  srp_byte_t rx_q, rx_d, rx_next;
  srp_byte_t tx_q, tx_d;
  logic push_valid;
  srp_wr_s push_data;
  logic byte_end;

  always_comb begin
    rx_next = {rx_q[6:0], sdi};
    byte_end = bit_q == `SRP_BIT_LAST;
    rd_addr = (phase_q == PH_CMD) ? rx_next[7:1] : ptr_q;
  end

  // read data source for the addressed entry
  always_comb begin
    if (rd_addr == `SRP_ADDR_STATUS) begin
      rd_byte = stat_sync_q;
    end else if (rd_addr == `SRP_ADDR_ID) begin
      rd_byte = ID_CODE;
    end else if (rd_addr < `SRP_ADDR_ID) begin
      rd_byte = mirror_q[rd_addr[5:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    phase_d = phase_q;
    bit_d = bit_q + 3'h1;
    ptr_d = ptr_q;
    rx_d = rx_q;
    tx_d = tx_q;
    push_valid = 1'b0;
    push_data = '{addr: ptr_q, data: rx_next};
    case (phase_q)
      PH_CMD: begin
        rx_d = rx_next;
        if (byte_end) begin
          ptr_d = rx_next[7:1];
          if (rx_next[0] == `SRP_CMD_READ) begin
            phase_d = PH_RD;
            tx_d = rd_byte;
            ptr_d = ptr_next(rx_next[7:1]);
          end else begin
            phase_d = PH_WR;
          end
        end
      end
      PH_WR: begin
        rx_d = rx_next;
        if (byte_end) begin
          ptr_d = ptr_next(ptr_q);
          if (srp_writable(ptr_q) && fifo_ready) begin
            push_valid = 1'b1;
          end
        end
      end
      PH_RD: begin
        // sdi is not looked at here
        if (byte_end) begin
          tx_d = rd_byte;
          ptr_d = ptr_next(ptr_q);
        end else begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
      default: begin
        phase_d = PH_CMD;
      end
    endcase
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_q <= PH_CMD;
      bit_q <= 3'h0;
      ptr_q <= 7'h00;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      bit_q <= bit_d;
      ptr_q <= ptr_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end

  // ----------------------------------------------------------------
  // mirror update on each accepted write byte
  // ----------------------------------------------------------------
  always_comb begin
    mirror_d = mirror_q;
    if (push_valid) begin
      mirror_d[push_data.addr[5:0]] = push_data.data;
    end
  end

  always_ff @(posedge sclk or posedge link_rst_q) begin
    if (link_rst_q) begin
      for (int i = 0; i < `SRP_MAP_SIZE; i++) begin
        mirror_q[i] <= srp_default(7'(i));
      end
    end else begin
      mirror_q <= mirror_d;
    end
  end

  // ----------------------------------------------------------------
  // serial output driver on the falling edge
  // ----------------------------------------------------------------
  logic drv_q, drv_d;
  logic sdo_q, sdo_d;

  always_comb begin
    drv_d = phase_q == PH_RD;
    sdo_d = tx_q[7];
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      drv_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      sdo_q <= sdo_d;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe_n = ~drv_q;

  // ----------------------------------------------------------------
  // write fifo into the system clock
  // ----------------------------------------------------------------
  logic pop_valid;
  logic pop_ready;
  srp_wr_s pop_data;

  srp_fifo #(
    .WIDTH($bits(srp_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(sclk),
    .wr_rst(link_rst_q),
    .wr_valid(push_valid),
    .wr_ready(fifo_ready),
    .wr_data(push_data),
    .rd_clk(mclk),
    .rd_rst(sys_rst),
    .rd_valid(pop_valid),
    .rd_ready(pop_ready),
    .rd_data(pop_data)
  );

  assign pop_ready = ~core_busy;

  // ----------------------------------------------------------------
  // core register image
  // ----------------------------------------------------------------
  srp_byte_t image_q [`SRP_MAP_SIZE];
  srp_byte_t image_d [`SRP_MAP_SIZE];
  logic evt_q, evt_d;
  srp_wr_s evt_data_q, evt_data_d;
  logic pop;

  always_comb begin
    pop = pop_valid & pop_ready;
    image_d = image_q;
    evt_d = pop;
    evt_data_d = evt_data_q;
    if (pop) begin
      image_d[pop_data.addr[5:0]] = pop_data.data;
      evt_data_d = pop_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `SRP_MAP_SIZE; i++) begin
        image_q[i] <= srp_default(7'(i));
      end
      evt_q <= 1'b0;
      evt_data_q <= '0;
    end else begin
      image_q <= image_d;
      evt_q <= evt_d;
      evt_data_q <= evt_data_d;
    end
  end

  always_comb begin
    for (int i = 0; i < `SRP_MAP_SIZE; i++) begin
      reg_image[i*8 +: 8] = image_q[i];
    end
  end

  assign wr_evt = evt_q;
  assign wr_evt_data = evt_data_q;

endmodule

/* File: tb/srp_port_chk.sv */
// assertion checker of the serial register port
`timescale 1ns/1ps
`include "srp_defines.svh"

module srp_port_chk
  import srp_pkg::*;
(
  // system side
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] core_status,
  input wire logic core_busy,
  input wire logic [`SRP_MAP_SIZE*8-1:0] reg_image,
  input wire logic wr_evt,
  input wire srp_wr_s wr_evt_data,
  // link side
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic fifo_ready
);
  // ----
  // frame tracking
  // ----
  logic [4:0] cnt_q;
  logic [7:0] cmd_q;

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 5'h00;
      cmd_q <= 8'h00;
    end else begin
      if (cnt_q < 5'h08) cmd_q <= {cmd_q[6:0], sdi};
      if (cnt_q < 5'h10) cnt_q <= cnt_q + 5'h01;
    end
  end

  // ----
  // properties
  // ----
  property p_oe_cmd;
    @(posedge sclk) disable iff (sys_rst || cs_n) cnt_q < 5'h08 |-> sdo_oe_n;
  endproperty
  a_oe_cmd: assert property (p_oe_cmd) else $error("early drive");
  property p_oe_wr;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      cnt_q >= 5'h08 && !cmd_q[0] |-> sdo_oe_n;
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("write drive");
  property p_oe_rd;
    @(posedge sclk) disable iff (sys_rst || cs_n)
      cnt_q >= 5'h08 && cmd_q[0] |-> !sdo_oe_n;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("no read drive");
  property p_oe_idle;
    @(posedge mclk) disable iff (sys_rst) cs_n |-> sdo_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("idle drive");
  property p_busy;
    @(posedge mclk) disable iff (sys_rst) core_busy |=> !wr_evt;
  endproperty
  a_busy: assert property (p_busy) else $error("write while busy");
  property p_img;
    @(posedge mclk) disable iff (sys_rst) wr_evt |->
      ##[0:1] reg_image[wr_evt_data.addr*8 +: 8] == wr_evt_data.data;
  endproperty
  a_img: assert property (p_img) else $error("image not written");
  property p_ro;
    @(posedge mclk) disable iff (sys_rst)
      wr_evt |-> wr_evt_data.addr != 7'h00 && wr_evt_data.addr < 7'h38;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only written");
  property p_id;
    @(posedge mclk) disable iff (sys_rst) reg_image[455:448] == 8'h00;
  endproperty
  a_id: assert property (p_id) else $error("id entry changed");
  property p_chg;
    @(posedge mclk) disable iff (sys_rst)
      $changed(reg_image) |-> wr_evt || $past(wr_evt);
  endproperty
  a_chg: assert property (p_chg) else $error("stray image change");
endmodule

bind srp_port srp_port_chk chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .core_status(core_status),
  .core_busy(core_busy), .reg_image(reg_image), .wr_evt(wr_evt),
  .wr_evt_data(wr_evt_data), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
  .sdo(sdo), .sdo_oe_n(sdo_oe_n), .fifo_ready(fifo_ready)
);

/* File: tb/srp_master_model.sv */
// serial bus master model for the register port link
`timescale 1ns/1ps

module srp_master_model (
  // link
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic fifo_ready
);
  logic [7:0] tx [0:31];
  logic [7:0] rx [0:31];
  logic acc [0:31];
  logic sdo_w;

  // pull-down on the shared line
  assign sdo_w = sdo_oe_n ? 1'b0 : sdo;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // one frame of nbits clocks, clock still outside it
  task automatic burst(input int nbits);
    cs_n = 1'b0;
    #7;
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[i / 8][7 - i % 8];
      #3;
      if (i % 8 == 7) acc[i / 8] = fifo_ready;
      sclk = 1'b1;
      rx[i / 8][7 - i % 8] = sdo_w;
      #3;
      sclk = 1'b0;
    end
    #5;
    cs_n = 1'b1;
    sdi = ~sdi;
    #12;
  endtask
endmodule

/* File: tb/spi_register_port_tb.sv */
// self-checking bench of the serial register port
`timescale 1ns/1ps
`include "srp_defines.svh"

module spi_register_port_tb
  import srp_pkg::*;
;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] core_status = 8'h00;
  logic core_busy = 1'b0;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe_n, fifo_ready, wr_evt;
  logic [`SRP_MAP_SIZE*8-1:0] reg_image;
  srp_wr_s wr_evt_data;
  logic [7:0] mem [0:56];
  int n_mismatch = 0;
  int checks_done = 0;
  int q;
  logic full;

  always #25 mclk = ~mclk;

  srp_port #(.ID_CODE(ID)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .core_status(core_status), .core_busy(core_busy),
    .reg_image(reg_image), .wr_evt(wr_evt), .wr_evt_data(wr_evt_data),
    .fifo_ready(fifo_ready));
  srp_master_model mst_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .fifo_ready(fifo_ready));

  // ----
  // expectations and checks
  // ----
  function automatic logic [7:0] dflt(input int a);
    case (a)
      1: return 8'haa;
      2: return 8'h08;
      6: return 8'h0c;
      7: return 8'h01;
      9: return 8'h2d;
      10: return 8'h93;
      11: return 8'h86;
      default: return 8'h00;
    endcase
  endfunction

  function automatic int nxt(input int a);
    return (a >= 56) ? 0 : a + 1;
  endfunction

  function automatic logic [7:0] rd_exp(input int a);
    if (a == 0) return core_status;
    if (a == 56) return ID;
    if (a > 56) return 8'h00;
    return mem[a];
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic img_chk();
    #1;
    for (int a = 0; a < 57; a++)
      chk("image", reg_image[a*8 +: 8], (a % 56 == 0) ? 8'h00 : mem[a]);
  endtask

  // write burst of n data bytes, last cut bits left off
  task automatic wr(input int a, input int n, input int cut);
    int p;
    p = a;
    mst_u.tx[0] = {a[6:0], 1'b0};
    for (int i = 1; i <= n; i++) mst_u.tx[i] = 8'($urandom);
    mst_u.burst(8 * n + 8 - cut);
    for (int i = 1; i <= n; i++) begin
      if (i * 8 + 8 <= 8 * n + 8 - cut && mst_u.acc[i] && p % 56 != 0)
        mem[p] = mst_u.tx[i];
      p = nxt(p);
    end
    repeat (20) @(posedge mclk);
  endtask

  task automatic rd(input int a, input int n);
    int p;
    p = a;
    @(posedge mclk);
    core_status <= 8'($urandom);
    @(posedge mclk);
    mst_u.tx[0] = {a[6:0], 1'b1};
    for (int i = 1; i <= n; i++) mst_u.tx[i] = 8'($urandom);
    mst_u.burst(8 * n + 8);
    for (int i = 1; i <= n; i++) begin
      chk("read", mst_u.rx[i], rd_exp(p));
      p = nxt(p);
    end
  endtask

  // ----
  // sequence
  // ----
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    void'($urandom(92485));
    for (int a = 0; a < 57; a++) mem[a] = dflt(a);
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    img_chk();
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      wr($urandom_range(56), $urandom_range(4, 1), 0);
      rd($urandom_range(63), 3);
    end
    img_chk();
    $display("test random done");
    wr(54, 5, 0);
    rd(55, 4);
    rd(60, 2);
    img_chk();
    $display("test wrap done");
    wr(20, 2, 3);
    img_chk();
    $display("test partial done");
    core_busy <= 1'b1;
    wr(1, 24, 0);
    full = 1'b0;
    for (int i = 1; i <= 24; i++) full |= !mst_u.acc[i];
    chk("refused", {7'h00, full}, 8'h01);
    core_busy <= 1'b0;
    q = 0;
    for (int t = 0; t < 300 && q < 10; t++) begin
      @(posedge mclk);
      #1;
      q = wr_evt ? 0 : q + 1;
    end
    if (q < 10) begin
      n_mismatch++;
    end
    rd(1, 24);
    img_chk();
    $display("test fill done");
    close_out();
  end
endmodule
